// ==== hw/ssm_fifo.sv ====
// synchronous fifo holding tagged samples ahead of the stage
// assumes pushes and pops on the same clock
`timescale 1ns/10ps
module ssm_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  ssm_fifo_if.fifo port
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  // full and empty straight from the occupancy count
  assign port.in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign port.out_valid = (cnt_ff != '0);
  assign port.out_data = mem_ff[rptr_ff];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  // storage has no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= port.in_data;
    end
  end

  // pointers wrap at depth, which must be a power of two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + 1'b1;
      if (pop) rptr_ff <= rptr_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

// ==== hw/ssm_stats_master.sv ====
// statistics and mastering stage with avalon-mm register port
// assumes samples arrive tagged with a source index, one per beat
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ssm_stats_master #(
  parameter int FIFO_DEPTH = ssm_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [ssm_pkg::SRC_W-1:0] in_src,
  input wire logic [ssm_pkg::DW-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [ssm_pkg::SRC_W-1:0] out_src,
  output logic [ssm_pkg::DW-1:0] out_data,
  input wire logic multifunction_input_one,
  output logic [ssm_pkg::N_STAT-1:0][ssm_pkg::DW-1:0] stat_min,
  output logic [ssm_pkg::N_STAT-1:0][ssm_pkg::DW-1:0] stat_max,
  output logic [ssm_pkg::N_STAT-1:0][ssm_pkg::DW-1:0] stat_peak,
  output logic [ssm_pkg::N_STAT-1:0] stat_valid
);
  import ssm_pkg::*;

  function automatic logic [7:0] at(input logic [7:0] base,
                                    input int idx, input int stride);
    return base + 8'(idx * stride);
  endfunction

  function automatic logic signed [31:0] sat(input logic [31:0] v);
    logic signed [31:0] s;
    s = signed'(v);
    if (s > MV_MAX) return MV_MAX;
    if (s < -MV_MAX) return -MV_MAX;
    return s;
  endfunction

  function automatic logic [3:0] dlim(input logic [3:0] v);
    if (v < DLOG_MIN) return DLOG_MIN;
    if (v > DLOG_MAX) return DLOG_MAX;
    return v;
  endfunction

  // bus side
  logic ack_ff;
  logic wr_en;
  logic [7:0] baddr;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [31:0] rdata_ff;

  // datapath side
  logic fire;
  logic [SRC_W-1:0] smp_src;
  logic signed [DW-1:0] x;
  logic signed [DW-1:0] mst_out;
  logic out_valid_ff;
  logic [SRC_W-1:0] out_src_ff;
  logic [DW-1:0] out_data_ff;

  // master slots
  logic slot_def_ff [N_SLOT];
  logic [SRC_W-1:0] slot_src_ff [N_SLOT];
  logic signed [31:0] slot_mval_ff [N_SLOT];
  logic signed [31:0] slot_off_ff [N_SLOT];
  logic [N_SLOT-1:0] slot_act_ff;
  logic [N_SLOT-1:0] slot_pend_ff;
  logic [N_SLOT-1:0] ext_sel_ff;
  logic ext_all_ff;
  logic trig_src_ff;
  logic mfi_prev_ff;
  logic trig;
  logic [N_SLOT-1:0] cap;
  logic [N_SLOT-1:0] do_set;
  logic [N_SLOT-1:0] do_rst;
  logic cmd_wr;

  // stats channels
  logic [SRC_W-1:0] st_src_ff [N_STAT];
  logic [N_STAT-1:0] st_en_ff;
  logic [N_STAT-1:0] st_inf_ff;
  logic [3:0] st_dlog_ff [N_STAT];
  logic signed [DW-1:0] st_min_ff [N_STAT];
  logic signed [DW-1:0] st_max_ff [N_STAT];
  logic signed [DW-1:0] st_peak_ff [N_STAT];
  logic [N_STAT-1:0] st_hmin_ff;
  logic [N_STAT-1:0] st_hmax_ff;
  logic [CNT_W-1:0] st_cnt_ff [N_STAT];
  logic [N_STAT-1:0] st_hit;
  logic [N_STAT-1:0] st_wend;
  logic [N_STAT-1:0] clr_min;
  logic [N_STAT-1:0] clr_max;
  logic signed [DW-1:0] nxt_min [N_STAT];
  logic signed [DW-1:0] nxt_max [N_STAT];
  logic sr_wr;

  // input fifo, its ready is the upstream back-pressure
  ssm_fifo_if #(.W(SRC_W + DW)) fq ();
  assign fq.in_valid = in_valid;
  assign fq.in_data = {in_src, in_data};
  assign in_ready = fq.in_ready;
  assign fq.out_ready = !out_valid_ff || out_ready;
  assign fire = fq.out_valid && fq.out_ready;
  assign smp_src = fq.out_data[DW +: SRC_W];
  assign x = signed'(fq.out_data[DW-1:0]);

  ssm_fifo #(.W(SRC_W + DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .port(fq)
  );

  // one wait state per access so read data can be registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign baddr = {avs_address, 2'b00};
  assign wd = avs_writedata;
  // partial writes are ignored, every field needs the whole word
  assign wr_en = avs_write && ack_ff && (avs_byteenable == 4'hf);
  assign avs_readdata = rdata_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ack_ff <= 1'b0;
    else ack_ff <= (avs_read || avs_write) && !ack_ff;
  end

  // read data latched in the waited cycle, stands until next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_ff <= RD_ZERO;
    else if (avs_read && !ack_ff) rdata_ff <= rd;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd = RD_ZERO;
    if (baddr == OFF_MSTAT) begin
      for (int i = 0; i < N_SLOT; i++) begin
        rd[i] = slot_def_ff[i];
        rd[MS_ACT + i] = slot_act_ff[i];
      end
    end
    if (baddr == OFF_SACT) rd[N_STAT-1:0] = st_en_ff;
    if (baddr == OFF_XSEL) rd = {21'h0, ext_all_ff, ext_sel_ff};
    if (baddr == OFF_TSRC) rd = {31'h0, trig_src_ff};
    for (int i = 0; i < N_SLOT; i++) begin
      if (baddr == at(OFF_SLOT, i, SLOT_STRIDE))
        rd = {27'h0, slot_def_ff[i], slot_src_ff[i]};
      if (baddr == at(OFF_SLOT, i, SLOT_STRIDE) + 8'h04)
        rd = slot_mval_ff[i];
    end
    for (int c = 0; c < N_STAT; c++) begin
      if (baddr == at(OFF_SCFG, c, 4))
        rd = {22'h0, st_dlog_ff[c], st_inf_ff[c], st_en_ff[c],
              st_src_ff[c]};
      if (baddr == at(OFF_SRES, c, SRES_STRIDE)) rd = st_min_ff[c];
      if (baddr == at(OFF_SRES, c, SRES_STRIDE) + 8'h04)
        rd = st_max_ff[c];
      if (baddr == at(OFF_SRES, c, SRES_STRIDE) + 8'h08)
        rd = st_peak_ff[c];
      if (baddr == at(OFF_SRES, c, SRES_STRIDE) + 8'h0c)
        rd = {18'h0, st_cnt_ff[c]};
    end
  end

  // trigger source and external selection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_src_ff <= 1'b0;
      ext_sel_ff <= '0;
      ext_all_ff <= 1'b0;
    end else begin
      if (wr_en && baddr == OFF_TSRC) trig_src_ff <= wd[0];
      if (wr_en && baddr == OFF_XSEL) begin
        ext_sel_ff <= wd[N_SLOT-1:0];
        ext_all_ff <= wd[XS_ALL];
      end
    end
  end

  // input one is already synchronous, only its rise is used
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mfi_prev_ff <= 1'b0;
    else mfi_prev_ff <= multifunction_input_one;
  end

  assign trig = trig_src_ff && multifunction_input_one && !mfi_prev_ff;
  assign cmd_wr = wr_en && (baddr == OFF_MCMD);

  // set and reset decode per slot
  always_comb begin
    for (int i = 0; i < N_SLOT; i++) begin
      do_set[i] = slot_def_ff[i] &&
        ((cmd_wr && wd[MC_SET] &&
          (wd[MC_ALL] || wd[SRC_W-1:0] == 4'(i))) ||
         (trig && (ext_all_ff || ext_sel_ff[i])));
      do_rst[i] = cmd_wr && !wd[MC_SET] &&
        (wd[MC_ALL] || wd[SRC_W-1:0] == 4'(i));
    end
  end

  // lowest matching slot wins when two share a source
  always_comb begin
    logic found;
    found = 1'b0;
    mst_out = x;
    cap = '0;
    for (int i = 0; i < N_SLOT; i++) begin
      if (!found && slot_def_ff[i] && slot_src_ff[i] == smp_src &&
          (slot_act_ff[i] || slot_pend_ff[i])) begin
        found = 1'b1;
        if (slot_pend_ff[i]) begin
          mst_out = slot_mval_ff[i];
          cap[i] = fire;
        end else begin
          mst_out = x + slot_off_ff[i];
        end
      end
    end
  end

  // master slot state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N_SLOT; i++) begin
        slot_def_ff[i] <= 1'b0;
        slot_src_ff[i] <= '0;
        slot_mval_ff[i] <= '0;
        slot_off_ff[i] <= '0;
      end
      slot_act_ff <= '0;
      slot_pend_ff <= '0;
    end else begin
      for (int i = 0; i < N_SLOT; i++) begin
        if (wr_en && baddr == at(OFF_SLOT, i, SLOT_STRIDE)) begin
          slot_def_ff[i] <= wd[SD_DEF];
          slot_src_ff[i] <= wd[SRC_W-1:0];
          slot_act_ff[i] <= 1'b0;
          slot_pend_ff[i] <= 1'b0;
        end else begin
          if (cap[i]) begin
            slot_off_ff[i] <= slot_mval_ff[i] - x;
            slot_act_ff[i] <= 1'b1;
            slot_pend_ff[i] <= 1'b0;
          end
          if (do_rst[i]) begin
            slot_act_ff[i] <= 1'b0;
            slot_pend_ff[i] <= 1'b0;
          end
          if (do_set[i]) slot_pend_ff[i] <= 1'b1;
        end
        if (wr_en && baddr == at(OFF_SLOT, i, SLOT_STRIDE) + 8'h04)
          slot_mval_ff[i] <= sat(wd);
      end
    end
  end

  // output register, holds while downstream stalls
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_ff <= 1'b0;
      out_src_ff <= '0;
      out_data_ff <= '0;
    end else if (fq.out_ready) begin
      out_valid_ff <= fq.out_valid;
      if (fire) begin
        out_src_ff <= smp_src;
        out_data_ff <= mst_out;
      end
    end
  end

  assign out_valid = out_valid_ff;
  assign out_src = out_src_ff;
  assign out_data = out_data_ff;
  assign sr_wr = wr_en && (baddr == OFF_SRST);

  // stats next values, a restart in the sample cycle keeps the sample
  always_comb begin
    for (int c = 0; c < N_STAT; c++) begin
      st_hit[c] = fire && st_en_ff[c] && st_src_ff[c] == smp_src;
      st_wend[c] = !st_inf_ff[c] &&
        st_cnt_ff[c] == (CNT_W'(1) << st_dlog_ff[c]);
      clr_min[c] = sr_wr && (wd[SR_ALL] || (wd[SR_CH] == 1'(c) &&
        wd[SR_WHAT +: 2] != SR_MAX));
      clr_max[c] = sr_wr && (wd[SR_ALL] || (wd[SR_CH] == 1'(c) &&
        wd[SR_WHAT +: 2] != SR_MIN));
      nxt_min[c] = (!st_hmin_ff[c] || st_wend[c] || clr_min[c] ||
        mst_out < st_min_ff[c]) ? mst_out : st_min_ff[c];
      nxt_max[c] = (!st_hmax_ff[c] || st_wend[c] || clr_max[c] ||
        mst_out > st_max_ff[c]) ? mst_out : st_max_ff[c];
    end
  end

  // stats channel state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < N_STAT; c++) begin
        st_src_ff[c] <= '0;
        st_dlog_ff[c] <= DLOG_MIN;
        st_min_ff[c] <= '0;
        st_max_ff[c] <= '0;
        st_peak_ff[c] <= '0;
        st_cnt_ff[c] <= '0;
      end
      st_en_ff <= '0;
      st_inf_ff <= '0;
      st_hmin_ff <= '0;
      st_hmax_ff <= '0;
    end else begin
      for (int c = 0; c < N_STAT; c++) begin
        if (wr_en && baddr == at(OFF_SCFG, c, 4)) begin
          st_src_ff[c] <= wd[SRC_W-1:0];
          st_en_ff[c] <= wd[SC_EN];
          st_inf_ff[c] <= wd[SC_INF];
          st_dlog_ff[c] <= dlim(wd[SC_DLOG +: 4]);
          st_hmin_ff[c] <= 1'b0;
          st_hmax_ff[c] <= 1'b0;
          st_cnt_ff[c] <= '0;
        end else if (st_hit[c]) begin
          st_min_ff[c] <= nxt_min[c];
          st_max_ff[c] <= nxt_max[c];
          st_peak_ff[c] <= nxt_max[c] - nxt_min[c];
          st_hmin_ff[c] <= 1'b1;
          st_hmax_ff[c] <= 1'b1;
          if (st_wend[c] || (clr_min[c] && clr_max[c]))
            st_cnt_ff[c] <= CNT_W'(1);
          else if (st_inf_ff[c] && &st_cnt_ff[c])
            st_cnt_ff[c] <= st_cnt_ff[c];
          else
            st_cnt_ff[c] <= st_cnt_ff[c] + 1'b1;
        end else begin
          if (clr_min[c]) st_hmin_ff[c] <= 1'b0;
          if (clr_max[c]) st_hmax_ff[c] <= 1'b0;
          if (clr_min[c] && clr_max[c]) st_cnt_ff[c] <= '0;
        end
      end
    end
  end

  // derived signals straight from the stats flops
  always_comb begin
    for (int c = 0; c < N_STAT; c++) begin
      stat_min[c] = st_min_ff[c];
      stat_max[c] = st_max_ff[c];
      stat_peak[c] = st_peak_ff[c];
      stat_valid[c] = st_en_ff[c] && st_hmin_ff[c] && st_hmax_ff[c];
    end
  end
endmodule

// ==== pkg/ssm_fifo_if.sv ====
// carrier between the stage and its input fifo
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface ssm_fifo_if #(parameter int W = 36);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface

// ==== pkg/ssm_pkg.sv ====
// constants for the signal statistics and mastering stage
// assumes one 40 MHz clock and a 32-bit Avalon-MM register port
// What this block does
// - min, max, peak per stats source
// - derived values driven out as signals
// - unbounded option accumulates since restart
// - none option removes stats channel
// - stats reset restarts from next sample
// - master pairs signal with bounded mm value
// - none definition frees master slot
// - ten master slots, any source
// - set activates, reset restores raw value
// - all applies to every defined slot
// - zero master value means zeroing
// - selection picks externally mastered slots
// - trigger source none or input one
// - status reports all ten slots
// - query lists definitions and stats sources
// - reset all, or one min/max/peak
package ssm_pkg;
  localparam int DW = 32;
  localparam int SRC_W = 4;
  localparam int N_SLOT = 10;
  localparam int N_STAT = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 14;
  // master value in nm, limit +-2147.0 mm
  localparam logic signed [31:0] MV_MAX = 32'sd2147000000;
  localparam logic [3:0] DLOG_MIN = 4'h1;
  localparam logic [3:0] DLOG_MAX = 4'hd;
  // byte offsets
  localparam logic [7:0] OFF_SCFG = 8'h00;
  localparam logic [7:0] OFF_SRST = 8'h08;
  localparam logic [7:0] OFF_MCMD = 8'h0c;
  localparam logic [7:0] OFF_XSEL = 8'h10;
  localparam logic [7:0] OFF_TSRC = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_SACT = 8'h1c;
  localparam logic [7:0] OFF_SLOT = 8'h20;
  localparam int SLOT_STRIDE = 8;
  localparam logic [7:0] OFF_SRES = 8'h80;
  localparam int SRES_STRIDE = 16;
  // stats config fields
  localparam int SC_EN = 4;
  localparam int SC_INF = 5;
  localparam int SC_DLOG = 6;
  // stats reset fields and selectors
  localparam int SR_ALL = 0;
  localparam int SR_CH = 1;
  localparam int SR_WHAT = 2;
  localparam logic [1:0] SR_MIN = 2'h0;
  localparam logic [1:0] SR_MAX = 2'h1;
  // master command, definition, selection and status fields
  localparam int MC_ALL = 4;
  localparam int MC_SET = 5;
  localparam int SD_DEF = 4;
  localparam int XS_ALL = 10;
  localparam int MS_ACT = 16;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ==== test/ssm_checker.sv ====
// assertions on the stage's pins
// assumes the register map and timing of the stage
`timescale 1ns/10ps
module ssm_checker
  import ssm_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [SRC_W-1:0] in_src,
  input wire logic [DW-1:0] in_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [SRC_W-1:0] out_src,
  input wire logic [DW-1:0] out_data,
  input wire logic multifunction_input_one,
  input wire logic [N_STAT-1:0][DW-1:0] stat_min,
  input wire logic [N_STAT-1:0][DW-1:0] stat_max,
  input wire logic [N_STAT-1:0][DW-1:0] stat_peak,
  input wire logic [N_STAT-1:0] stat_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a stalled beat must not change under the consumer
  out_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_src))
    else $error("output moved while stalled");
  peak_diff_a: assert property (stat_valid[0] |->
    stat_peak[0] == stat_max[0] - stat_min[0])
    else $error("peak is not max minus min");
  min_le_max_a: assert property (stat_valid[0] |->
    $signed(stat_min[0]) <= $signed(stat_max[0]))
    else $error("minimum above maximum");
  rd_wait_a: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait state");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest &&
    avs_address >= 6'h28 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  slot_count_a: assert property (avs_read && avs_waitrequest &&
    avs_address == OFF_MSTAT[7:2] |=>
    avs_readdata[15:10] == 6'h0 && avs_readdata[31:26] == 6'h0)
    else $error("status shows more than ten slots");
  stat_list_a: assert property (avs_read && avs_waitrequest &&
    avs_address == OFF_SACT[7:2] |=> avs_readdata[31:2] == 30'h0 &&
    (avs_readdata[1:0] & $past(stat_valid)) == $past(stat_valid))
    else $error("active channel list wrong");
  clear_restart_a: assert property (avs_write && !avs_waitrequest &&
    avs_address == OFF_SRST[7:2] && avs_writedata[0] &&
    avs_byteenable == 4'hf |=> (!stat_valid[0] || stat_peak[0] == 0) &&
    (!stat_valid[1] || stat_peak[1] == 0))
    else $error("statistics not restarted");
  stat_seen_c: cover property (stat_valid[0]);
  stall_seen_c: cover property (out_valid && !out_ready);
  full_seen_c: cover property (!in_ready);
endmodule
bind ssm_stats_master ssm_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_valid, .in_ready,
  .in_src, .in_data, .out_valid, .out_ready, .out_src, .out_data,
  .multifunction_input_one, .stat_min, .stat_max, .stat_peak, .stat_valid
);

// ==== test/ssm_src_model.sv ====
// sample source and sink standing in for the measurement front end
// assumes the bench fills q and pops what lands in got
`timescale 1ns/10ps
module ssm_src_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic in_ready,
  output logic in_valid,
  output logic [ssm_pkg::SRC_W-1:0] in_src,
  output logic [ssm_pkg::DW-1:0] in_data,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [ssm_pkg::SRC_W-1:0] out_src,
  input wire logic [ssm_pkg::DW-1:0] out_data
);
  logic [35:0] q[$];
  logic [35:0] got[$];
  // hold each sample until taken, then offer the next
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_valid <= 1'b0;
      in_src <= 4'h0;
      in_data <= 32'h0;
      out_ready <= 1'b1;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) got.push_back({out_src, out_data});
      if (!in_valid || in_ready) begin
        if (q.size() > 0) begin
          {in_src, in_data} <= q.pop_front();
          in_valid <= 1'b1;
        end else begin
          in_valid <= 1'b0;
          // idle lines toggle so a stale sample never looks valid
          in_data <= ~in_data;
        end
      end
    end
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the statistics and mastering stage
// assumes the checker binds itself and the source model is compiled
`timescale 1ns/10ps
module tb;
  import ssm_pkg::*;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, stall;
  logic in_valid, in_ready, out_valid, out_ready, multifunction_input_one;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable, in_src, out_src, be;
  logic [31:0] avs_writedata, avs_readdata, in_data, out_data, rd;
  logic [N_STAT-1:0][DW-1:0] stat_min, stat_max, stat_peak;
  logic [N_STAT-1:0] stat_valid;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  ssm_stats_master #(.FIFO_DEPTH(16)) i_dut (.clk, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .in_valid, .in_ready, .in_src, .in_data, .out_valid,
    .out_ready, .out_src, .out_data, .multifunction_input_one, .stat_min,
    .stat_max, .stat_peak, .stat_valid);
  ssm_src_model i_src (.clk, .arst_n, .stall, .in_ready, .in_valid, .in_src,
    .in_data, .out_valid, .out_ready, .out_src, .out_data);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a[7:2];
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    // no wait limit here, only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic send(input logic [3:0] s, input logic [31:0] d);
    i_src.q.push_back({s, d});
  endtask
  task automatic expo(input logic [3:0] s, input logic [31:0] d);
    logic [35:0] v;
    int k;
    k = 0;
    while (i_src.got.size() == 0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (i_src.got.size() == 0) i_src.got.push_back('x);
    v = i_src.got.pop_front();
    chk({28'h0, v[35:32]}, {28'h0, s});
    chk(v[31:0], d);
  endtask
  task automatic stc(input logic [31:0] mn, input logic [31:0] mx);
    tick(4);
    chk(stat_min[0], mn);
    chk(stat_max[0], mx);
    chk(stat_peak[0], mx - mn);
    chk({31'h0, stat_valid[0]}, 32'h1);
  endtask
  task automatic pulse();
    @(posedge clk);
    multifunction_input_one <= 1'b1;
    @(posedge clk);
    multifunction_input_one <= 1'b0;
    tick(2);
  endtask
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    be = 4'hf;
    stall = 1'b0;
    multifunction_input_one = 1'b0;
    tick(6);
    arst_n <= 1'b1;
    rdc(OFF_MSTAT, 32'h0);
    rdc(OFF_SACT, 32'h0);
    rdc(8'hc0, 32'h0);
    // unbounded statistics over source 1
    wr(OFF_SCFG, 32'h31);
    send(4'h1, 32'h5);
    send(4'h1, 32'hffff_fffd);
    send(4'h1, 32'ha);
    expo(4'h1, 32'h5);
    expo(4'h1, 32'hffff_fffd);
    expo(4'h1, 32'ha);
    stc(32'hffff_fffd, 32'ha);
    rdc(OFF_SACT, 32'h1);
    rdc(OFF_SRES, 32'hffff_fffd);
    rdc(OFF_SRES + 8'h8, 32'hd);
    wr(OFF_SRST, 32'h1);
    send(4'h1, 32'h7);
    expo(4'h1, 32'h7);
    stc(32'h7, 32'h7);
    send(4'h1, 32'h3);
    send(4'h1, 32'h9);
    expo(4'h1, 32'h3);
    expo(4'h1, 32'h9);
    wr(OFF_SRST, 32'h4);
    send(4'h1, 32'h5);
    expo(4'h1, 32'h5);
    stc(32'h3, 32'h5);
    // window of two samples, third starts a new one
    wr(OFF_SCFG, 32'h51);
    send(4'h1, 32'h4);
    send(4'h1, 32'h8);
    expo(4'h1, 32'h4);
    expo(4'h1, 32'h8);
    stc(32'h4, 32'h8);
    send(4'h1, 32'h1);
    expo(4'h1, 32'h1);
    stc(32'h1, 32'h1);
    wr(OFF_SCFG, 32'h0);
    tick(4);
    chk({31'h0, stat_valid[0]}, 32'h0);
    rdc(OFF_SACT, 32'h0);
    // second channel, unbounded over source 6
    wr(8'h04, 32'h36);
    send(4'h6, 32'h2);
    send(4'h6, 32'h9);
    expo(4'h6, 32'h2);
    expo(4'h6, 32'h9);
    tick(4);
    chk(stat_min[1], 32'h2);
    chk(stat_max[1], 32'h9);
    chk(stat_peak[1], 32'h7);
    chk({31'h0, stat_valid[1]}, 32'h1);
    rdc(8'h9c, 32'h2);
    rdc(OFF_SACT, 32'h2);
    // zeroing then offset on source 2
    wr(OFF_SLOT, 32'h12);
    wr(OFF_SLOT + 8'h4, 32'h0);
    rdc(OFF_MSTAT, 32'h1);
    wr(OFF_MCMD, 32'h20);
    send(4'h2, 32'h1f4);
    send(4'h2, 32'h258);
    expo(4'h2, 32'h0);
    expo(4'h2, 32'h64);
    rdc(OFF_MSTAT, 32'h0001_0001);
    wr(OFF_MCMD, 32'h0);
    send(4'h2, 32'h258);
    expo(4'h2, 32'h258);
    // slot three on source 3, then set all
    wr(8'h38, 32'h13);
    wr(8'h3c, 32'h3e8);
    wr(OFF_MCMD, 32'h30);
    send(4'h3, 32'hfa);
    send(4'h2, 32'h28);
    expo(4'h3, 32'h3e8);
    expo(4'h2, 32'h0);
    rdc(OFF_MSTAT, 32'h0009_0009);
    wr(OFF_MCMD, 32'h10);
    rdc(OFF_MSTAT, 32'h9);
    // pin trigger, first with no source chosen
    wr(OFF_XSEL, 32'h8);
    wr(OFF_TSRC, 32'h0);
    pulse();
    send(4'h3, 32'hfa);
    expo(4'h3, 32'hfa);
    wr(OFF_TSRC, 32'h1);
    pulse();
    send(4'h3, 32'hfa);
    send(4'h2, 32'h28);
    expo(4'h3, 32'h3e8);
    expo(4'h2, 32'h28);
    // selection of all defined slots arms both slots
    wr(OFF_XSEL, 32'h400);
    pulse();
    send(4'h3, 32'h1f4);
    send(4'h2, 32'h28);
    expo(4'h3, 32'h3e8);
    expo(4'h2, 32'h0);
    wr(8'h3c, 32'h7fff_ffff);
    rdc(8'h3c, MV_MAX);
    wr(OFF_SLOT, 32'h0);
    rdc(OFF_MSTAT, 32'h0008_0008);
    be = 4'h3;
    wr(8'h48, 32'h15);
    be = 4'hf;
    rdc(OFF_MSTAT, 32'h0008_0008);
    // fill the queue against a stalled consumer, then drain
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) send(4'h5, i);
    tick(40);
    n = 19 - i_src.q.size();
    chk({31'h0, in_ready}, 32'h0);
    chk({31'h0, n == 16 || n == 17}, 32'h1);
    stall <= 1'b0;
    for (int i = 0; i < 20; i++) expo(4'h5, i);
    close_out();
  end
endmodule
